// *** aux_seq_map.svh ***
// Register offsets, field positions, reset values and timing of the channel sequencer
`ifndef AUX_SEQ_MAP_SVH
`define AUX_SEQ_MAP_SVH
`define SEQ_CTRL_OFS 12'h000
`define SEQ_CMD_OFS 12'h004
`define SEQ_STEP_EN_OFS 12'h008
`define SEQ_STATUS_OFS 12'h00c
`define SEQ_CFG_BASE 12'h040
`define SEQ_RES_BASE 12'h080
`define CTRL_EN_BIT 0
`define CTRL_STBY_BIT 1
`define CTRL_DLY_LSB 2
`define CTRL_MODE_LSB 5
`define CMD_START_BIT 0
`define CMD_STOP_BIT 1
`define CTRL_RESET 32'h0000_0002
`define STEP_EN_RESET 16'h0000
`define STEP_CFG_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define SETTLE_BASE_NS 1000
`define PCLK_PERIOD_NS 40
`define SETTLE_BASE_CYC ((`SETTLE_BASE_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`endif

// *** aux_seq_pkg.sv ***
// Types shared by the channel sequencer
package aux_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_SYNC = 2'b10,
    MODE_ALT = 2'b11
  } seq_mode_t;
  // Per-step converter setup
  typedef struct packed {
    logic [6:0] rsvd;
    logic [2:0] gain;
    logic [2:0] neg_sel;
    logic [2:0] pos_sel;
  } step_cfg_t;
  // Request to the converter
  typedef struct packed {
    logic start;
    step_cfg_t cfg;
  } conv_req_t;
endpackage

// *** aux_adc_channel_sequencer.sv ***
// Channel sequencer for the auxiliary converter with an APB register slave
// Notes on behaviour
// R1 - Sixteen steps, each with an enable bit, one conversion per enabled step.
// R2 - Each step applies its own gain and positive and negative input selection.
// R3 - Runs start at step 0, ascend through enabled steps, skip disabled ones.
// R4 - A global 3-bit field picks the settling delay before each conversion.
// R5 - Run time is enabled steps times settling delay plus conversion time.
// R6 - Running flag is high exactly while a run is in progress.
// R7 - Host leaves the configuration registers alone while the converter is enabled.
// R8 - Host disables, configures, re-enables, then starts, to avoid spurious runs.
// R9 - A start written while the converter is disabled is ignored.
// R10 - Each step result is 16 bits in its own readable register.
// R11 - Results of disabled steps read zero after a run completes.
// R12 - All results update together at run end; reads never mix runs.
// R13 - Two-bit mode field picks continuous, single-shot or synchronized single-shot.
// R14 - Continuous mode repeats runs; a start mid-run aborts and restarts.
// R15 - Stop lets the run finish; stop reads one until actually stopped.
// R16 - Disable, standby or power-down aborts any run at once.
// R17 - Start and stop in one write act as start; stop is ignored.
// R18 - Results stay after stop; cleared by reset, disable or standby.
// R19 - Single-shot does one run per start; restart on start; stop ignored.
// R20 - Synchronized mode: main conversion start triggers a run only when idle.
// R21 - Host writes start once to arm synchronized mode.
// R22 - With single-shot main converter, host writes both starts together.
// R23 - Control writes take effect at the completing edge of the write.
// R24 - Mode 00 continuous, 01 single, 10 synchronized, 11 as single-shot.
// R25 - Start is self-clearing, a one-cycle pulse into the sequencer.
`include "aux_seq_map.svh"
module aux_adc_channel_sequencer #(
  parameter int STEPS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_conversion_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output aux_seq_pkg::conv_req_t conv_req,
  output logic sequence_running_flag
);
  localparam int IW = $clog2(STEPS);

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] ctrl_q;
  logic [STEPS-1:0] step_enable_q;
  logic [15:0] step_config_q [STEPS];
  logic [15:0] step_result_q [STEPS];
  logic [15:0] shadow_q [STEPS];
  aux_seq_pkg::seq_state_t state_q;
  logic [IW-1:0] step_q;
  logic [11:0] wait_q;
  logic cont_q;
  logic armed_q;
  logic stop_pend_q;
  aux_seq_pkg::conv_req_t conv_req_q;
  logic running_q;

  // Returns the first enabled step at or above a given index, with a found bit
  function automatic logic [IW:0] next_step(input logic [STEPS-1:0] en, input int from);
    logic [IW:0] r;
    r = '0;
    for (int i = STEPS - 1; i >= 0; i--) begin
      if (i >= from && en[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  // Settling delay in cycles, doubling with each code
  function automatic logic [11:0] settle_cycles(input logic [2:0] sel);
    return 12'(`SETTLE_BASE_CYC) << sel;
  endfunction

  // Bus strobes: one wait state, write lands on the completing edge
  logic acc;
  logic wr;
  logic cfg_hit;
  logic res_hit;
  logic [IW-1:0] widx;
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign cfg_hit = paddr[11:6] == 6'(`SEQ_CFG_BASE >> 6);
  assign res_hit = paddr[11:6] == 6'(`SEQ_RES_BASE >> 6);
  assign widx = paddr[IW+1:2];

  // Decoded control fields
  logic active;
  aux_seq_pkg::seq_mode_t mode;
  logic [2:0] dly_sel;
  assign active = ctrl_q[`CTRL_EN_BIT] && !ctrl_q[`CTRL_STBY_BIT];
  assign mode = aux_seq_pkg::seq_mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
  assign dly_sel = ctrl_q[`CTRL_DLY_LSB +: 3];

  // R23 command at write edge
  logic cmd_wr;
  assign cmd_wr = wr && paddr == `SEQ_CMD_OFS;
  // R25 R9 start pulse, only when enabled
  logic start_p;
  assign start_p = cmd_wr && pwdata[`CMD_START_BIT] && active;
  // R17 R19 R15 stop only without start, continuous mode, while running
  logic stop_p;
  assign stop_p = cmd_wr && pwdata[`CMD_STOP_BIT] && !pwdata[`CMD_START_BIT] &&
                  mode == aux_seq_pkg::MODE_CONT && running_q;
  // R20 synchronized trigger only when idle
  logic sync_p;
  assign sync_p = armed_q && mode == aux_seq_pkg::MODE_SYNC && main_conversion_start &&
                  state_q == aux_seq_pkg::ST_IDLE && active && !start_p;

  // Run launch and completion
  logic launch;
  logic [IW:0] first;
  logic [IW:0] nxt;
  logic last_done;
  logic again;
  assign launch = start_p || sync_p;
  assign first = next_step(step_enable_q, 0);
  assign nxt = next_step(step_enable_q, int'(step_q) + 1);
  assign last_done = state_q == aux_seq_pkg::ST_CONV && conv_done &&
                     (!nxt[IW] || int'(step_q) == STEPS - 1);
  assign again = cont_q && !stop_pend_q;

  // APB answer path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (cfg_hit) begin
        prdata_q <= {16'h0000, step_config_q[widx]};
      end else if (res_hit) begin
        // R10 per-step result readback
        prdata_q <= {16'h0000, step_result_q[widx]};
      end else begin
        case (paddr)
          `SEQ_CTRL_OFS: prdata_q <= ctrl_q;
          // R15 stop reads one while pending
          `SEQ_CMD_OFS: prdata_q <= {30'h0, stop_pend_q, 1'b0};
          `SEQ_STEP_EN_OFS: prdata_q <= 32'(step_enable_q);
          `SEQ_STATUS_OFS: prdata_q <= {24'h0, 4'(step_q), 2'b00, stop_pend_q, running_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Control and step registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      step_enable_q <= `STEP_EN_RESET;
      for (int i = 0; i < STEPS; i++) begin
        step_config_q[i] <= `STEP_CFG_RESET;
      end
    end else if (wr) begin
      if (paddr == `SEQ_CTRL_OFS) begin
        ctrl_q <= {25'h0, pwdata[6:0]};
      end
      if (paddr == `SEQ_STEP_EN_OFS) begin
        // R1 step enables
        step_enable_q <= pwdata[STEPS-1:0];
      end
      if (cfg_hit) begin
        step_config_q[widx] <= pwdata[15:0];
      end
    end
  end

  // Mode latches: continuous, armed and stop pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_q <= 1'b0;
      armed_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (!active) begin
      cont_q <= 1'b0;
      armed_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (start_p) begin
      // R13 R24 mode decides repeat or arm
      cont_q <= mode == aux_seq_pkg::MODE_CONT;
      armed_q <= mode == aux_seq_pkg::MODE_SYNC;
      stop_pend_q <= 1'b0;
    end else if (stop_p) begin
      stop_pend_q <= 1'b1;
    end else if (last_done && !again) begin
      // R15 stop clears once halted
      cont_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end
  end

  // Step walker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= aux_seq_pkg::ST_IDLE;
      step_q <= '0;
      wait_q <= 12'h000;
      conv_req_q <= '0;
      running_q <= 1'b0;
    end else begin
      conv_req_q.start <= 1'b0;
      if (!active) begin
        // R16 immediate abort
        state_q <= aux_seq_pkg::ST_IDLE;
        running_q <= 1'b0;
      end else if (launch || (last_done && again)) begin
        // R3 R14 R19 restart from the lowest enabled step
        step_q <= first[IW-1:0];
        wait_q <= settle_cycles(dly_sel);
        state_q <= first[IW] ? aux_seq_pkg::ST_SETTLE : aux_seq_pkg::ST_IDLE;
        running_q <= first[IW];
        // R2 step setup applied
        conv_req_q.cfg <= aux_seq_pkg::step_cfg_t'(step_config_q[first[IW-1:0]]);
      end else begin
        case (state_q)
          aux_seq_pkg::ST_SETTLE: begin
            // R4 R5 settle then convert
            if (wait_q <= 12'h001) begin
              state_q <= aux_seq_pkg::ST_CONV;
              conv_req_q.start <= 1'b1;
            end else begin
              wait_q <= wait_q - 12'h001;
            end
          end
          aux_seq_pkg::ST_CONV: begin
            if (last_done) begin
              // R6 run finished
              state_q <= aux_seq_pkg::ST_IDLE;
              running_q <= 1'b0;
            end else if (conv_done) begin
              step_q <= nxt[IW-1:0];
              wait_q <= settle_cycles(dly_sel);
              state_q <= aux_seq_pkg::ST_SETTLE;
              conv_req_q.cfg <= aux_seq_pkg::step_cfg_t'(step_config_q[nxt[IW-1:0]]);
            end
          end
          default: state_q <= aux_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Shadow capture and whole-set result update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STEPS; i++) begin
        shadow_q[i] <= `RESULT_RESET;
        step_result_q[i] <= `RESULT_RESET;
      end
    end else if (!active) begin
      // R18 cleared by disable or standby
      for (int i = 0; i < STEPS; i++) begin
        step_result_q[i] <= `RESULT_RESET;
      end
    end else if (state_q == aux_seq_pkg::ST_CONV && conv_done && !launch) begin
      shadow_q[step_q] <= conv_data;
      if (last_done) begin
        // R12 R11 all results at once, disabled steps zero
        for (int i = 0; i < STEPS; i++) begin
          step_result_q[i] <= !step_enable_q[i] ? `RESULT_RESET :
                              (IW'(i) == step_q) ? conv_data : shadow_q[i];
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_req = conv_req_q;
  assign sequence_running_flag = running_q;

  // Checks
  property p_ignore_start; // R9
    @(posedge pclk) disable iff (!presetn)
      (cmd_wr && pwdata[`CMD_START_BIT] && !active && !running_q) |=> !running_q;
  endproperty
  a_ignore_start: assert property (p_ignore_start) // R9
    else $error("start accepted while disabled");
  property p_abort; // R16
    @(posedge pclk) disable iff (!presetn)
      !active |=> !running_q && state_q == aux_seq_pkg::ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) // R16
    else $error("run survived disable");
  property p_clear_res; // R18
    @(posedge pclk) disable iff (!presetn)
      !active |=> step_result_q[0] == 16'h0000 && step_result_q[STEPS-1] == 16'h0000;
  endproperty
  a_clear_res: assert property (p_clear_res) // R18
    else $error("results kept after disable");
  property p_stable_res; // R12
    @(posedge pclk) disable iff (!presetn)
      (active && !last_done) |=> $stable(step_result_q[0]);
  endproperty
  a_stable_res: assert property (p_stable_res) // R12
    else $error("result changed mid run");
  property p_zero_dis; // R11
    @(posedge pclk) disable iff (!presetn)
      (last_done && !launch && !step_enable_q[1]) |=> step_result_q[1] == 16'h0000;
  endproperty
  a_zero_dis: assert property (p_zero_dis) // R11
    else $error("disabled step result not zero");
  property p_start_wins; // R17
    @(posedge pclk) disable iff (!presetn)
      (start_p && pwdata[`CMD_STOP_BIT]) |=> !stop_pend_q;
  endproperty
  a_start_wins: assert property (p_start_wins) // R17
    else $error("stop taken with start");
  property p_stop_finish; // R15
    @(posedge pclk) disable iff (!presetn)
      (stop_pend_q && running_q && active && !start_p) |=> stop_pend_q || !running_q;
  endproperty
  a_stop_finish: assert property (p_stop_finish) // R15
    else $error("stop cleared before halt");
  property p_sync_no_abort; // R20
    @(posedge pclk) disable iff (!presetn)
      (state_q == aux_seq_pkg::ST_CONV && main_conversion_start && !start_p && active &&
       !conv_done) |=> state_q == aux_seq_pkg::ST_CONV && $stable(step_q);
  endproperty
  a_sync_no_abort: assert property (p_sync_no_abort) // R20
    else $error("trigger disturbed a run");
  // R4 cycles spent settling in the current step
  logic [11:0] settle_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_q <= 12'h000;
    end else if (state_q != aux_seq_pkg::ST_SETTLE || launch || !active) begin
      settle_cnt_q <= 12'h000;
    end else if (settle_cnt_q != 12'hfff) begin
      settle_cnt_q <= settle_cnt_q + 12'h001;
    end
  end
  property p_settle; // R4
    @(posedge pclk) disable iff (!presetn)
      conv_req_q.start |-> settle_cnt_q == (12'(`SETTLE_BASE_CYC) << dly_sel);
  endproperty
  a_settle: assert property (p_settle) // R4
    else $error("conversion before settling");
  property p_start_pulse; // R25
    @(posedge pclk) disable iff (!presetn)
      conv_req_q.start |=> !conv_req_q.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) // R25
    else $error("start pulse too long");
  c_run_done: cover property (@(posedge pclk) disable iff (!presetn) last_done);
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) start_p && running_q);
  c_sync: cover property (@(posedge pclk) disable iff (!presetn) sync_p);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn) stop_p);
endmodule

// *** aux_conv_model.sv ***
// Behavioural auxiliary converter that answers the sequencer's requests
module aux_conv_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire aux_seq_pkg::conv_req_t conv_req,
  input wire logic [7:0] lat,
  output logic conv_done,
  output logic [15:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [7:0] wait_q;
  logic [15:0] sample_q;
  // A request restarts the count; when it runs out one sample is returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      wait_q <= 8'h00;
      sample_q <= 16'h1001;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else if (conv_req.start) begin
      busy_q <= 1'b1;
      wait_q <= lat;
      conv_done <= 1'b0;
      conv_data <= ~conv_data; // Data toggles outside the done cycle
    end else if (busy_q && wait_q == 8'h00) begin
      busy_q <= 1'b0;
      sample_q <= sample_q + 16'h0101;
      conv_done <= 1'b1;
      conv_data <= sample_q;
    end else begin
      wait_q <= wait_q - {7'h00, busy_q};
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
  end
endmodule

// *** aux_adc_channel_sequencer_bench.sv ***
// Self-checking bench of the auxiliary converter channel sequencer
`include "aux_seq_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module aux_adc_channel_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic main_conversion_start, conv_done, sequence_running_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] conv_data, en, c;
  logic [15:0] seen [16];
  logic [7:0] lat;
  logic [8:0] order [$];
  aux_seq_pkg::conv_req_t conv_req;
  int err_count, cmp_count, cyc, t_up, t_cf;

  aux_adc_channel_sequencer #(.STEPS(16)) u_aux_adc_channel_sequencer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_conversion_start(main_conversion_start), .conv_done(conv_done),
    .conv_data(conv_data), .conv_req(conv_req), .sequence_running_flag(sequence_running_flag));
  aux_conv_model u_aux_conv_model (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

  // Clock of 40 ns
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Log each request and keep the sample returned for its step
  always @(posedge pclk) begin
    cyc++;
    if (conv_req.start) begin
      order.push_back(conv_req.cfg[8:0]);
      if (order.size() == 1) t_cf = cyc;
    end
    if (conv_done) seen[{conv_req.cfg.neg_sel[0], conv_req.cfg.pos_sel}] = conv_data;
    if (sequence_running_flag && t_up < 0) t_up = cyc;
  end

  function automatic logic [15:0] cfg_of(input logic [3:0] n);
    return {7'h00, 3'(n + 4'h1), 2'b00, n};
  endfunction

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (sequence_running_flag !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (sequence_running_flag !== v) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic pulse;
    main_conversion_start <= 1'b1;
    @(posedge pclk);
    main_conversion_start <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic setup(input logic [1:0] m, input logic [2:0] s, input logic [15:0] e);
    en = e;
    seen = '{default: 16'h0};
    wr(`SEQ_CTRL_OFS, 32'h0);
    wr(`SEQ_STEP_EN_OFS, {16'h0, e});
    for (int n = 0; n < 16; n++) wr(`SEQ_CFG_BASE + 12'(4 * n), {16'h0, cfg_of(4'(n))});
    wr(`SEQ_CTRL_OFS, {25'h0, m, s, 2'b01});
  endtask

  task automatic go;
    order.delete();
    t_up = -1;
    wr(`SEQ_CMD_OFS, 32'h1);
    wait_run(1'b1, 4);
  endtask

  // Order, settings, settle time and results of one finished run
  task automatic check_run(input logic [2:0] s);
    int k, d;
    k = 0;
    d = t_cf - t_up;
    `CHK(order.size(), $countones(en))
    `CHK(d >= (`SETTLE_BASE_CYC << s) && d <= (`SETTLE_BASE_CYC << s) + 2, 1'b1)
    for (int n = 0; n < 16; n++) begin
      c = cfg_of(4'(n));
      if (en[n]) begin
        `CHK(order[k], c[8:0])
        k++;
      end
      rchk(`SEQ_RES_BASE + 12'(4 * n), en[n] ? {16'h0, seen[n]} : 32'h0);
    end
  endtask

  task automatic t_reset;
    rchk(`SEQ_CTRL_OFS, `CTRL_RESET);
    rchk(`SEQ_RES_BASE, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(perr, 1'b1)
    wr(`SEQ_CMD_OFS, 32'h1);
    repeat (30) @(posedge pclk);
    `CHK(sequence_running_flag, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_single(input logic [1:0] m, input logic [2:0] s, input logic [7:0] l);
    lat <= l;
    setup(m, s, 16'h8005);
    repeat (2) begin
      go();
      rchk(`SEQ_RES_BASE, {16'h0, seen[0]});
      wr(`SEQ_CMD_OFS, 32'h2);
      rchk(`SEQ_CMD_OFS, 32'h0);
      wait_run(1'b0, 3000);
      check_run(s);
    end
    repeat (60) @(posedge pclk);
    `CHK(sequence_running_flag, 1'b0)
    $display("test single mode %0d done", m);
  endtask

  task automatic t_cont;
    setup(2'b00, 3'd0, 16'h0012);
    go();
    repeat (400) @(posedge pclk);
    `CHK(order.size() > 4 && sequence_running_flag === 1'b1, 1'b1)
    wr(`SEQ_CMD_OFS, 32'h3);
    rchk(`SEQ_CMD_OFS, 32'h0);
    wr(`SEQ_CMD_OFS, 32'h2);
    rchk(`SEQ_CMD_OFS, 32'h2);
    wait_run(1'b0, 500);
    rchk(`SEQ_CMD_OFS, 32'h0);
    rchk(`SEQ_RES_BASE + 12'h004, {16'h0, seen[1]});
    rchk(`SEQ_RES_BASE, 32'h0);
    $display("test continuous done");
  endtask

  task automatic t_abort;
    go();
    wr(`SEQ_CTRL_OFS, 32'h0);
    @(posedge pclk);
    `CHK(sequence_running_flag, 1'b0)
    rchk(`SEQ_RES_BASE + 12'h004, 32'h0);
    wr(`SEQ_CMD_OFS, 32'h1);
    repeat (30) @(posedge pclk);
    `CHK(sequence_running_flag, 1'b0)
    $display("test abort done");
  endtask

  task automatic t_sync;
    setup(2'b10, 3'd0, 16'h0101);
    pulse();
    repeat (5) @(posedge pclk);
    `CHK(sequence_running_flag, 1'b0)
    go();
    wait_run(1'b0, 1000);
    order.delete();
    pulse();
    wait_run(1'b1, 4);
    repeat (10) @(posedge pclk);
    pulse();
    for (int n = 0; n < 200 && conv_req.start !== 1'b1; n++) @(posedge pclk);
    pulse();
    wait_run(1'b0, 1000);
    `CHK(order.size(), 2)
    order.delete();
    // sequence start and main conversion start on one edge
    fork
      wr(`SEQ_CMD_OFS, 32'h1);
      begin
        repeat (2) @(posedge pclk);
        pulse();
      end
    join
    wait_run(1'b0, 1000);
    `CHK(order.size(), 2)
    $display("test synchronized done");
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    main_conversion_start = 1'b0;
    lat = 8'h03;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single(2'b01, 3'd0, 8'h00);
    t_single(2'b11, 3'd2, 8'h09);
    t_cont();
    t_abort();
    t_sync();
    complete_run();
  end
endmodule
